// file: rtl/timer16_normal_mode_control.v
// 16-bit timer control: registers, counter, buffers, waveform pins
// assumes an AXI4-Lite master on ref_clk and a sleep level on ref_clk
// Function
// RQ1 - standby_run set keeps timer running in standby; clear halts it
// RQ2 - prescale_select codes divide clock by 1,2,4,8,16,64,256,1024
// RQ3 - timer runs only while enable bit is one
// RQ4 - in frequency and PWM modes pin enable routes waveform to pin
// RQ5 - auto-lock holds lock set until all enabled buffer-valid bits set
// RQ6 - lock then stays clear until update copies buffers and relocks
// RQ7 - without auto-lock only software changes the lock bit
// RQ8 - TOP is period for modes 0,3,5,6,7 and compare zero for 1
// RQ9 - update and overflow points follow the waveform mode
// RQ10 - normal mode produces no waveform on outputs
// RQ11 - software sets port pin direction to output for waveforms
// RQ12 - lock blocks update copies; forced update command still copies
// RQ13 - buffer write sets its valid bit; update clears all valid bits
// RQ14 - interrupt asserted while a flag and its enable are both set
// RQ15 - prescaler ticks the counter and restarts when disabled
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "timer16_defines.vh"

module timer16_normal_mode_control (
  input  wire        ref_clk,
  input  wire        resetn,
  input  wire        standby_sleep,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [2:0]  waveform_pin_out,
  output reg  [2:0]  waveform_pin_oe,
  output reg         irq
);

  // software state
  reg  [7:0]  ctrl_primary_reg;
  reg  [7:0]  ctrl_waveform_reg;
  reg  [2:0]  override_reg;
  reg         split_reg;
  reg  [7:0]  event_ctrl_reg;
  reg  [7:0]  int_enable_reg;
  reg         debug_reg;
  reg  [7:0]  staging_reg;
  // timer state
  reg  [15:0] counter_reg;
  reg  [15:0] period_reg;
  reg  [15:0] period_buf_reg;
  reg  [15:0] compare_reg [0:2];
  reg  [15:0] compare_buf_reg [0:2];
  reg         dir_reg;
  reg         lock_reg;
  reg  [3:0]  buf_valid_reg;
  reg  [7:0]  flags_reg;
  reg  [2:0]  wave_reg;
  // bus state
  reg         aw_full_reg;
  reg         w_full_reg;
  reg  [5:0]  wr_idx_reg;
  reg  [31:0] wr_data_reg;
  reg  [3:0]  wr_strb_reg;

  wire        wr_go;
  wire        rd_go;
  wire [5:0]  rd_idx;
  wire        wr_b0;
  wire [7:0]  wr_byte;
  wire        run;
  wire        tick;
  wire [2:0]  mode;
  wire        auto_lock;
  wire [2:0]  pin_en;
  wire        dual;
  wire [15:0] top;
  wire        at_top;
  wire        at_bot;
  wire        upd_cond;
  wire        all_valid;
  wire        cmd_wr;
  wire [1:0]  cmd;
  wire        cmd_update;
  wire        cmd_restart;
  wire        do_copy;
  wire [2:0]  hit;
  wire        waveform_mode;
  reg         ovf_ev;
  reg  [31:0] rd_word;
  reg         rd_mapped;
  integer     n, nb, nw;

  // merge a 16-bit register with the two low write lanes
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    begin
      merge16 = {strb[1] ? data[15:8] : old[15:8],
                 strb[0] ? data[7:0] : old[7:0]};
    end
  endfunction

  // decode the running conditions
  assign wr_go     = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign rd_go     = s_axi_arvalid & s_axi_arready;
  assign rd_idx    = s_axi_araddr[7:2];
  assign wr_b0     = wr_strb_reg[0];
  assign wr_byte   = wr_data_reg[7:0];
  assign mode      = ctrl_waveform_reg[2:0];
  assign auto_lock = ctrl_waveform_reg[`BIT_AUTO_LOCK];
  assign pin_en    = ctrl_waveform_reg[6:4];
  // sleep level is produced on ref_clk by the power controller
  assign run = ctrl_primary_reg[`BIT_ENABLE] & // RQ3
               (~standby_sleep | ctrl_primary_reg[`BIT_STANDBY_RUN]); // RQ1

  prescale_divider u_prescale (
    .ref_clk         (ref_clk),
    .resetn          (resetn),
    .run             (run),
    .prescale_select (ctrl_primary_reg[3:1]),
    .tick            (tick)
  );

  // counting points for the selected mode
  assign dual = (mode == `WMODE_TWO_HIGH) | (mode == `WMODE_TWO_BOTH) |
                (mode == `WMODE_TWO_LOW);
  assign top  = (mode == `WMODE_FREQ) ? compare_reg[0] : period_reg; // RQ8
  assign at_top = (counter_reg == top);
  assign at_bot = (counter_reg == `RST_WORD);
  assign upd_cond = tick & (((mode == `WMODE_NORMAL) |
                             (mode == `WMODE_FREQ)) ? (~dir_reg & at_top)
                                                    : at_bot); // RQ9
  assign waveform_mode = (mode == `WMODE_FREQ) | (mode == `WMODE_ONE_RAMP) |
                         dual;

  // overflow point per mode
  always @* begin
    case (mode)
      `WMODE_NORMAL,
      `WMODE_FREQ:     ovf_ev = tick & (dir_reg ? at_bot : at_top); // RQ9
      `WMODE_ONE_RAMP: ovf_ev = tick & at_bot; // RQ9
      `WMODE_TWO_HIGH: ovf_ev = tick & at_top; // RQ9
      `WMODE_TWO_BOTH: ovf_ev = tick & (at_top | at_bot); // RQ9
      `WMODE_TWO_LOW:  ovf_ev = tick & at_bot; // RQ9
      default:         ovf_ev = 1'b0;
    endcase
  end

  // commands come through either command/direction register
  assign cmd_wr = wr_go & wr_b0 & ((wr_idx_reg == `IDX_CMD_DIR_SET) |
                                   (wr_idx_reg == `IDX_CMD_DIR_CLR));
  assign cmd         = wr_byte[3:2];
  assign cmd_update  = cmd_wr & (cmd == `CMD_UPDATE);
  assign cmd_restart = cmd_wr & ((cmd == `CMD_RESTART) |
                       ((cmd == `CMD_HARD_RESET) &
                        ~ctrl_primary_reg[`BIT_ENABLE]));
  assign do_copy = (upd_cond & ~lock_reg) | cmd_update; // RQ12
  // channels without a pin enable do not hold the lock
  assign all_valid = &(buf_valid_reg[3:1] | ~pin_en); // RQ5

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_hit
      assign hit[g] = tick & (counter_reg == compare_reg[g]);
    end
  endgenerate

  // write channel capture; ready falls until the response is taken
  always @(posedge ref_clk) begin
    if (!resetn) begin
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      wr_idx_reg    <= 6'h00;
      wr_data_reg   <= 32'h00000000;
      wr_strb_reg   <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg   <= 1'b1;
        wr_idx_reg    <= s_axi_awaddr[7:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg   <= 1'b1;
        wr_data_reg  <= s_axi_wdata;
        wr_strb_reg  <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_idx_reg == 6'h08 || wr_idx_reg == 6'h0C ||
                         wr_idx_reg == 6'h0D) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read data selection
  always @* begin
    rd_word   = 32'h00000000;
    rd_mapped = 1'b1;
    case (rd_idx)
      `IDX_CTRL_PRIMARY:  rd_word[7:0] = ctrl_primary_reg;
      `IDX_CTRL_WAVEFORM: rd_word[7:0] = ctrl_waveform_reg;
      `IDX_CTRL_OVERRIDE: rd_word[2:0] = override_reg;
      `IDX_CTRL_SPLIT:    rd_word[0]   = split_reg;
      `IDX_CMD_DIR_CLR,
      `IDX_CMD_DIR_SET:   rd_word[1:0] = {lock_reg, dir_reg};
      `IDX_BV_CLR,
      `IDX_BV_SET:        rd_word[3:0] = buf_valid_reg;
      `IDX_EVENT_CTRL:    rd_word[7:0] = event_ctrl_reg;
      `IDX_INT_ENABLE:    rd_word[7:0] = int_enable_reg;
      `IDX_INT_FLAGS:     rd_word[7:0] = flags_reg;
      `IDX_DEBUG_CTRL:    rd_word[0]   = debug_reg;
      `IDX_HIGH_STAGING:  rd_word[7:0] = staging_reg;
      `IDX_COUNTER:       rd_word[15:0] = counter_reg;
      `IDX_PERIOD:        rd_word[15:0] = period_reg;
      `IDX_COMPARE0:      rd_word[15:0] = compare_reg[0];
      `IDX_COMPARE1:      rd_word[15:0] = compare_reg[1];
      `IDX_COMPARE2:      rd_word[15:0] = compare_reg[2];
      `IDX_PERIOD_BUF:    rd_word[15:0] = period_buf_reg;
      `IDX_COMPARE_BUF0:  rd_word[15:0] = compare_buf_reg[0];
      `IDX_COMPARE_BUF1:  rd_word[15:0] = compare_buf_reg[1];
      `IDX_COMPARE_BUF2:  rd_word[15:0] = compare_buf_reg[2];
      default:            rd_mapped = 1'b0;
    endcase
  end

  // read channel: one cycle to the answer
  always @(posedge ref_clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (rd_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // plain control registers
  always @(posedge ref_clk) begin
    if (!resetn) begin
      ctrl_primary_reg  <= `RST_BYTE;
      ctrl_waveform_reg <= `RST_BYTE;
      override_reg      <= 3'h0;
      split_reg         <= 1'b0;
      event_ctrl_reg    <= `RST_BYTE;
      int_enable_reg    <= `RST_BYTE;
      debug_reg         <= 1'b0;
      staging_reg       <= `RST_BYTE;
    end else if (wr_go && wr_b0) begin
      case (wr_idx_reg)
        `IDX_CTRL_PRIMARY:
          ctrl_primary_reg <= wr_byte & `MASK_CTRL_PRIMARY;
        `IDX_CTRL_WAVEFORM:
          ctrl_waveform_reg <= wr_byte & `MASK_CTRL_WAVEFORM;
        `IDX_CTRL_OVERRIDE: override_reg   <= wr_byte[2:0];
        `IDX_CTRL_SPLIT:    split_reg      <= wr_byte[0];
        `IDX_EVENT_CTRL:    event_ctrl_reg <= wr_byte;
        `IDX_INT_ENABLE:    int_enable_reg <= wr_byte & `MASK_FLAGS;
        `IDX_DEBUG_CTRL:    debug_reg      <= wr_byte[0];
        `IDX_HIGH_STAGING:  staging_reg    <= wr_byte;
        default:            staging_reg    <= staging_reg;
      endcase
    end
  end

  // counter, direction and compare/period values
  always @(posedge ref_clk) begin
    if (!resetn) begin
      counter_reg <= `RST_WORD;
      dir_reg     <= 1'b0;
      period_reg  <= 16'hFFFF;
      for (n = 0; n < 3; n = n + 1) begin
        compare_reg[n] <= `RST_WORD;
      end
    end else begin
      // counting sequence; software writes below take precedence
      if (tick) begin
        if (dual) begin
          if (!dir_reg && at_top) begin
            dir_reg     <= 1'b1;
            counter_reg <= counter_reg - 16'h0001;
          end else if (dir_reg && at_bot) begin
            dir_reg     <= 1'b0;
            counter_reg <= counter_reg + 16'h0001;
          end else if (dir_reg) begin
            counter_reg <= counter_reg - 16'h0001;
          end else begin
            counter_reg <= counter_reg + 16'h0001;
          end
        end else if (dir_reg) begin
          counter_reg <= at_bot ? top : counter_reg - 16'h0001;
        end else begin
          counter_reg <= (counter_reg >= top) ? `RST_WORD
                                              : counter_reg + 16'h0001;
        end
      end
      // only buffers holding fresh data are transferred
      if (do_copy) begin
        if (buf_valid_reg[0]) period_reg <= period_buf_reg; // RQ12
        for (n = 0; n < 3; n = n + 1) begin
          if (buf_valid_reg[n+1]) compare_reg[n] <= compare_buf_reg[n]; // RQ6
        end
      end
      if (cmd_restart) begin
        counter_reg <= `RST_WORD;
        dir_reg     <= 1'b0;
      end
      if (wr_go) begin
        case (wr_idx_reg)
          `IDX_COUNTER:  counter_reg <= merge16(counter_reg, wr_data_reg,
                                                wr_strb_reg);
          `IDX_PERIOD:   period_reg <= merge16(period_reg, wr_data_reg,
                                               wr_strb_reg);
          `IDX_COMPARE0: compare_reg[0] <= merge16(compare_reg[0],
                                                   wr_data_reg, wr_strb_reg);
          `IDX_COMPARE1: compare_reg[1] <= merge16(compare_reg[1],
                                                   wr_data_reg, wr_strb_reg);
          `IDX_COMPARE2: compare_reg[2] <= merge16(compare_reg[2],
                                                   wr_data_reg, wr_strb_reg);
          `IDX_CMD_DIR_SET: if (wr_b0 && wr_byte[`BIT_DIR]) dir_reg <= 1'b1;
          `IDX_CMD_DIR_CLR: if (wr_b0 && wr_byte[`BIT_DIR]) dir_reg <= 1'b0;
          default: ;
        endcase
      end
    end
  end

  // buffers, their valid bits and the update lock
  always @(posedge ref_clk) begin
    if (!resetn) begin
      period_buf_reg <= 16'hFFFF;
      buf_valid_reg  <= 4'h0;
      lock_reg       <= 1'b0;
      for (nb = 0; nb < 3; nb = nb + 1) begin
        compare_buf_reg[nb] <= `RST_WORD;
      end
    end else begin
      if (do_copy) buf_valid_reg <= 4'h0; // RQ13
      // lock only moves on its own under auto-lock
      if (auto_lock) begin
        if (lock_reg && all_valid) begin
          lock_reg <= 1'b0; // RQ5
        end else if (!lock_reg && upd_cond) begin
          lock_reg <= 1'b1; // RQ6
        end
      end
      if (wr_go) begin
        case (wr_idx_reg)
          `IDX_PERIOD_BUF: begin
            period_buf_reg   <= merge16(period_buf_reg, wr_data_reg,
                                        wr_strb_reg);
            buf_valid_reg[0] <= 1'b1; // RQ13
          end
          `IDX_COMPARE_BUF0: begin
            compare_buf_reg[0] <= merge16(compare_buf_reg[0], wr_data_reg,
                                          wr_strb_reg);
            buf_valid_reg[1]   <= 1'b1; // RQ13
          end
          `IDX_COMPARE_BUF1: begin
            compare_buf_reg[1] <= merge16(compare_buf_reg[1], wr_data_reg,
                                          wr_strb_reg);
            buf_valid_reg[2]   <= 1'b1; // RQ13
          end
          `IDX_COMPARE_BUF2: begin
            compare_buf_reg[2] <= merge16(compare_buf_reg[2], wr_data_reg,
                                          wr_strb_reg);
            buf_valid_reg[3]   <= 1'b1; // RQ13
          end
          `IDX_BV_SET: if (wr_b0) buf_valid_reg <= buf_valid_reg |
                                                   wr_byte[3:0];
          `IDX_BV_CLR: if (wr_b0) buf_valid_reg <= buf_valid_reg &
                                                   ~wr_byte[3:0];
          `IDX_CMD_DIR_SET:
            if (wr_b0 && wr_byte[`BIT_LOCK]) lock_reg <= 1'b1; // RQ7
          `IDX_CMD_DIR_CLR:
            if (wr_b0 && wr_byte[`BIT_LOCK]) lock_reg <= 1'b0; // RQ7
          `IDX_CTRL_WAVEFORM: if (wr_b0 && wr_byte[`BIT_AUTO_LOCK])
            lock_reg <= 1'b1; // RQ5
          default: ;
        endcase
      end
    end
  end

  // sticky flags: read or write-one clears, a new event wins
  always @(posedge ref_clk) begin
    if (!resetn) begin
      flags_reg <= `RST_BYTE;
      irq       <= 1'b0;
    end else begin
      flags_reg <= ((rd_go && rd_idx == `IDX_INT_FLAGS) ? `RST_BYTE :
                    (wr_go && wr_b0 && wr_idx_reg == `IDX_INT_FLAGS) ?
                    (flags_reg & ~wr_byte) : flags_reg) |
                   {1'b0, hit, 3'h0, ovf_ev};
      irq <= |(flags_reg & int_enable_reg); // RQ14
    end
  end

  // waveform generator; override bits drive it while the enable bit is clear
  always @(posedge ref_clk) begin
    if (!resetn) begin
      wave_reg <= 3'h0;
    end else if (!ctrl_primary_reg[`BIT_ENABLE]) begin
      wave_reg <= override_reg;
    end else begin
      for (nw = 0; nw < 3; nw = nw + 1) begin
        case (mode)
          `WMODE_FREQ: if (hit[nw]) wave_reg[nw] <= ~wave_reg[nw];
          `WMODE_ONE_RAMP: begin
            if (hit[nw]) wave_reg[nw] <= 1'b0;
            else if (tick && at_bot) wave_reg[nw] <= 1'b1;
          end
          `WMODE_TWO_HIGH,
          `WMODE_TWO_BOTH,
          `WMODE_TWO_LOW: if (hit[nw]) wave_reg[nw] <= dir_reg;
          default: wave_reg[nw] <= wave_reg[nw]; // RQ10
        endcase
      end
    end
  end

  // pin drive; normal mode and disabled channels leave the port alone
  always @(posedge ref_clk) begin
    if (!resetn) begin
      waveform_pin_out <= 3'h0;
      waveform_pin_oe  <= 3'h0;
    end else begin
      waveform_pin_oe  <= pin_en & {3{waveform_mode}}; // RQ4
      waveform_pin_out <= wave_reg & pin_en & {3{waveform_mode}}; // RQ4
    end
  end

endmodule // timer16_normal_mode_control

`default_nettype wire

// file: rtl/timer16_defines.vh
// constant set of the 16-bit timer control block
// assumes inclusion by bare name from rtl/ files only
`ifndef TIMER16_DEFINES_VH
`define TIMER16_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_CTRL_PRIMARY   6'h00
`define IDX_CTRL_WAVEFORM  6'h01
`define IDX_CTRL_OVERRIDE  6'h02
`define IDX_CTRL_SPLIT     6'h03
`define IDX_CMD_DIR_CLR    6'h04
`define IDX_CMD_DIR_SET    6'h05
`define IDX_BV_CLR         6'h06
`define IDX_BV_SET         6'h07
`define IDX_EVENT_CTRL     6'h09
`define IDX_INT_ENABLE     6'h0A
`define IDX_INT_FLAGS      6'h0B
`define IDX_DEBUG_CTRL     6'h0E
`define IDX_HIGH_STAGING   6'h0F
`define IDX_COUNTER        6'h20
`define IDX_PERIOD         6'h26
`define IDX_COMPARE0       6'h28
`define IDX_COMPARE1       6'h2A
`define IDX_COMPARE2       6'h2C
`define IDX_PERIOD_BUF     6'h36
`define IDX_COMPARE_BUF0   6'h38
`define IDX_COMPARE_BUF1   6'h3A
`define IDX_COMPARE_BUF2   6'h3C

// field positions
`define BIT_ENABLE         0
`define BIT_STANDBY_RUN    7
`define BIT_AUTO_LOCK      3
`define BIT_DIR            0
`define BIT_LOCK           1
`define BIT_OVF_FLAG       0

// reset values and write masks
`define RST_BYTE           8'h00
`define RST_WORD           16'h0000
`define MASK_CTRL_PRIMARY  8'h8F
`define MASK_CTRL_WAVEFORM 8'h7F
`define MASK_FLAGS         8'h71

// waveform modes
`define WMODE_NORMAL       3'h0
`define WMODE_FREQ         3'h1
`define WMODE_ONE_RAMP     3'h3
`define WMODE_TWO_HIGH     3'h5
`define WMODE_TWO_BOTH     3'h6
`define WMODE_TWO_LOW      3'h7

// command codes
`define CMD_UPDATE         2'h1
`define CMD_RESTART        2'h2
`define CMD_HARD_RESET     2'h3

// bus answers
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// file: rtl/prescale_divider.v
// divider that turns the peripheral clock into counting ticks
// assumes run comes from logic on ref_clk
`timescale 1ns/100ps
`default_nettype none

module prescale_divider (
  input  wire       ref_clk,
  input  wire       resetn,
  input  wire       run,
  input  wire [2:0] prescale_select,
  output wire       tick
);

  reg  [9:0] div_reg;
  reg  [9:0] limit;

  // terminal count per code, divide ratio minus one
  always @* begin
    case (prescale_select)
      3'h0:    limit = 10'h000;
      3'h1:    limit = 10'h001;
      3'h2:    limit = 10'h003;
      3'h3:    limit = 10'h007;
      3'h4:    limit = 10'h00F;
      3'h5:    limit = 10'h03F;
      3'h6:    limit = 10'h0FF;
      default: limit = 10'h3FF;
    endcase
  end

  assign tick = run & (div_reg >= limit); // RQ2

  // restart from zero while stopped so the first period is whole
  always @(posedge ref_clk) begin
    if (!resetn || !run) begin
      div_reg <= 10'h000; // RQ15
    end else if (tick) begin
      div_reg <= 10'h000;
    end else begin
      div_reg <= div_reg + 10'h001; // RQ15
    end
  end

endmodule // prescale_divider

`default_nettype wire

// file: test/pin_model.sv
// pin model: pads of the three waveform channels
// assumes pin_out and pin_oe come straight from the timer block
`timescale 1ns/100ps
`default_nettype none
module pin_model (
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe,
  input  wire logic [2:0] port_val,
  input  wire logic [2:0] port_dir,
  output var  logic [2:0] pad
);
  // wave reaches a pad only on an output pin; inputs float high
  always_comb begin
    for (int i = 0; i < 3; i++)
      if (pin_oe[i] && port_dir[i]) pad[i] = pin_out[i];
      else if (port_dir[i]) pad[i] = port_val[i];
      else pad[i] = 1'b1;
  end
endmodule  // pin_model
`default_nettype wire

// file: test/timer16_asserts.sv
// checker: bus handshakes, reset state and pin gating
// assumes it is bound to the timer block, one clock domain
`timescale 1ns/100ps
`default_nettype none
module timer16_asserts (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [2:0]  waveform_pin_out,
  input wire logic [2:0]  waveform_pin_oe,
  input wire logic        irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // an unrouted channel must never leak a level
  property p_pin_gate;
    (waveform_pin_out & ~waveform_pin_oe) == 3'h0;
  endproperty
  a_pin_gate: assert property (p_pin_gate)
    else $error("pin leak");
  // quiet outputs right after reset
  property p_idle;
    $rose(resetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq
      && waveform_pin_oe == 3'h0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("not idle");
  // answers stand until taken
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("b dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("r dropped");
  // one write outstanding: no new request while answering
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_block: assert property (p_w_block)
    else $error("aw open");
  property p_w_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid;
  endproperty
  a_w_answer: assert property (p_w_answer)
    else $error("no b");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("no r");
  // hole in the map answers error with zero data
  property p_bad_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h08
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_bad_read: assert property (p_bad_read)
    else $error("hole read");
  c_irq: cover property ($rose(irq));
  c_pin: cover property (waveform_pin_oe != 3'h0);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule  // timer16_asserts
bind timer16_normal_mode_control timer16_asserts timer16_asserts_inst (.*);
`default_nettype wire

// file: test/timer16_normal_mode_control_tb_top.sv
// bench: register bus, lock logic, counting, interrupt and pin routing
// assumes checker and pin model are compiled ahead of this file
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module timer16_normal_mode_control_tb_top;
  typedef struct packed {
    logic [3:0] w; logic [7:0] i; logic [15:0] d, e; } row_t;
  logic        ref_clk = 1'b0, resetn = 1'b0, standby_sleep = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, last;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, irq;
  logic [2:0]  waveform_pin_out, waveform_pin_oe, pad;
  int          n_errors = 0, n_tests = 0, n, k, stamp[3];
  int          divs[8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
  // write, read back: masks, lock handling, buffer copies
  row_t        rows[25] = '{
    44'h1_00_00FF_008F, 44'h1_00_0000_0000, 44'h1_01_00FF_007F,
    44'h1_01_0000_0000, 44'h1_05_0002_0002, 44'h1_38_1111_1111,
    44'h0_05_0000_0002, 44'h0_07_0000_0002, 44'h1_05_0004_0002,
    44'h0_28_0000_1111, 44'h0_07_0000_0000, 44'h1_04_0002_0000,
    44'h1_01_0038_0038, 44'h0_05_0000_0002, 44'h1_38_2222_2222,
    44'h0_05_0000_0002, 44'h1_3A_3333_3333, 44'h0_05_0000_0000,
    44'h1_3C_4444_4444, 44'h1_26_0002_0002, 44'h1_00_0001_0001,
    44'h0_26_0000_0002, 44'h0_05_0000_0002, 44'h0_2C_0000_4444,
    44'h1_00_0000_0000};
  timer16_normal_mode_control timer16_normal_mode_control_inst (.*);
  pin_model pin_model_inst (.pin_out(waveform_pin_out),
    .pin_oe(waveform_pin_oe), .port_val(3'h7), .port_dir(3'h7), .pad(pad));
  always #5 ref_clk = ~ref_clk;
  // both channels offered together, each dropped once taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    s_axi_awaddr <= {a, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k == 50) wrap_up();
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [5:0] a);
    s_axi_araddr <= {a, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd_data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k == 50) wrap_up();
    @(posedge ref_clk);
  endtask
  // fixed window from a restarted prescaler; bus overhead gives slack
  task automatic meas(input logic [7:0] c, input int x);
    int hi = x + (x > 0 ? 4 : 0);
    wr(6'h00, 32'h0);
    wr(6'h20, 32'h0);
    wr(6'h00, {24'h0, c});
    repeat (2048) @(posedge ref_clk);
    wr(6'h00, 32'h0);
    rd(6'h20);
    `CHK(rd_data[15:0] >= x && rd_data[15:0] <= hi, 1'b1)
  endtask
  task automatic wrap_up();
    if (k == 50) n_errors++;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    foreach (rows[r]) begin
      if (rows[r].w[0]) wr(rows[r].i[5:0], {16'h0, rows[r].d});
      rd(rows[r].i[5:0]);
      `CHK(rd_data, {16'h0, rows[r].e})
    end
    // overflow and zero-compare flags left from the run above
    wr(6'h0A, 32'h1);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b1)
    rd(6'h0B);
    `CHK(rd_data, 32'h61)
    repeat (40) @(posedge ref_clk);
    `CHK(irq, 1'b0)
    wr(6'h00, 32'h1);
    for (int j = 0; j < 16; j++) begin
      @(posedge ref_clk);
      `CHK(waveform_pin_out, 3'h0)
    end
    // frequency mode on channel 0, top at 3: half period of 4 ticks
    wr(6'h28, 32'h3);
    wr(6'h01, 32'h11);
    last = pad[0];
    for (int j = 0; j < 60 && n < 3; j++) begin
      @(posedge ref_clk);
      #1;
      if (pad[0] !== last) begin
        stamp[n] = j;
        n++;
        last = pad[0];
      end
    end
    `CHK(waveform_pin_oe, 3'h1)
    `CHK(pad[2:1], 2'h3)
    `CHK(stamp[2] - stamp[1], 4)
    wr(6'h01, 32'h0);
    wr(6'h26, 32'hFFFF);
    for (int j = 0; j < 8; j++) meas({4'h0, j[2:0], 1'b1}, 2048 / divs[j]);
    standby_sleep <= 1'b1;
    meas(8'h01, 0);
    meas(8'h81, 2048);
    resetn <= 1'b0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(6'h00);
    `CHK(rd_data, 32'h0)
    rd(6'h26);
    `CHK(rd_data, 32'hFFFF)
    rd(6'h08);
    `CHK(resp, 2'h2)
    wr(6'h0C, 32'h1);
    `CHK(resp, 2'h2)
    wrap_up();
  end
endmodule  // timer16_normal_mode_control_tb_top
`default_nettype wire
